// >>> verilog/switch_reset_sequencer_regs.svh
/*
 Offsets, field positions and timing counts of the reset sequencer.
 Assumes a 250 MHz core clock and an APB slave with 32-bit data.
*/
`ifndef SWITCH_RESET_SEQUENCER_REGS_SVH
`define SWITCH_RESET_SEQUENCER_REGS_SVH

`define CTRL_OFS        12'h000
`define STATUS_OFS      12'h004
`define STICKY_OFS      12'h008
`define SCRATCH_OFS     12'h00C

`define CTRL_FUNDAMENTAL_RESET_REQUEST_BIT   0
`define CTRL_HRST_BIT   1
`define CTRL_HALT_BIT   2
`define CTRL_USBR_BIT   3
`define CTRL_DSBR_LSB   4

`define STAT_HALT_BIT   3
`define STAT_COLD_BIT   4
`define STAT_WARM_BIT   5
`define STAT_FORCE_BIT  6
`define STAT_STATE_LSB  8

`define MODE_NORMAL     3'h0
`define MODE_EEPROM     3'h1

`define CLK_MHZ         250
`define TRAIN_LIMIT_MS  20
`define TRAIN_LIMIT_CYC (`TRAIN_LIMIT_MS * 1000 * `CLK_MHZ)
`define HOT_PULSE_CYC   16

`endif

// >>> verilog/switch_reset_sequencer_pkg.sv
/*
 Types of the switch reset sequencer: APB carriers and sequence states.
 Assumes the constants header is included by the design file.
*/
package switch_reset_sequencer_pkg;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_type;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } apb_rsp_type;

   typedef enum logic [7:0] {
      st_wait   = 8'h01,
      st_sample = 8'h02,
      st_decode = 8'h04,
      st_pll    = 8'h08,
      st_train  = 8'h10,
      st_halt   = 8'h20,
      st_quasi  = 8'h40,
      st_run    = 8'h80
   } seq_state_type;

endpackage

// >>> verilog/switch_reset_sequencer.sv
/*
 Reset sequencer of a four-port switch: fundamental, hot and secondary bus
 resets, strap capture, mode decode and the first normal-mode steps.
 Assumes asynchronous pins (reset, straps, PLL lock, lane ready) and an
 APB master on the core clock.
*/
// Implementation choices: the APB register port and the address map.
`timescale 1ns/10ps
`include "switch_reset_sequencer_regs.svh"

module switch_reset_sequencer #(
   parameter logic [24:0] TRAIN_LIMIT = 25'(`TRAIN_LIMIT_CYC)
) (
   input  wire logic                                 clock,
   input  wire logic                                 rst,
   input  wire switch_reset_sequencer_pkg::apb_req_type apb_req,
   output      switch_reset_sequencer_pkg::apb_rsp_type apb_rsp,
   input  wire logic                                 system_reset_in_n,
   input  wire logic [2:0]                           switch_mode_straps,
   input  wire logic                                 reset_halt,
   input  wire logic                                 pll_locked,
   input  wire logic                                 lanes_ready,
   input  wire logic                                 hot_reset_in,
   output      logic                                 core_reset,
   output      logic                                 logic_hot_reset,
   output      logic                                 pll_reset,
   output      logic                                 lane_reset,
   output      logic                                 link_train_enable,
   output      logic                                 stack_reset,
   output      logic                                 quasi_reset,
   output      logic                                 config_retry,
   output      logic                                 mode_normal,
   output      logic                                 mode_eeprom,
   output      logic                                 mode_test,
   output      logic [3:0]                           function_hot_reset,
   output      logic [2:0]                           link_hot_reset
);

   localparam int SYNC_W = 7;

   switch_reset_sequencer_pkg::seq_state_type state_q;
   switch_reset_sequencer_pkg::apb_rsp_type   rsp_q;

   logic [SYNC_W-1:0] meta_q;
   logic [SYNC_W-1:0] sync_q;
   logic              pin_rst_s;
   logic [2:0]        straps_s;
   logic              halt_s;
   logic              pll_s;
   logic              lanes_s;

   logic [2:0]  mode_q;
   logic        halt_stat_q;
   logic        halt_ctrl_q;
   logic        cold_q;
   logic        warm_q;
   logic        fresh_q;
   logic        pin_seen_q;
   logic        forced_q;
   logic        usbr_q;
   logic [2:0]  dsbr_q;
   logic [31:0] sticky_q;
   logic [31:0] scratch_q;
   logic [24:0] since_q;
   logic [4:0]  hot_cnt_q;
   logic        hot_active;

   logic        wr;
   logic        rd;
   logic        access;
   logic        fundamental_reset_request_pulse;
   logic        hrst_pulse;
   logic        fund_cond;
   logic        mapped;
   logic [31:0] rdata;

   // Pins pass two flops; only the second stage feeds logic
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= {lanes_ready, pll_locked, reset_halt,
                    switch_mode_straps, system_reset_in_n};
         sync_q <= meta_q;
      end
   end

   assign pin_rst_s = ~sync_q[0];
   assign straps_s  = sync_q[3:1];
   assign halt_s    = sync_q[4];
   assign pll_s     = sync_q[5];
   assign lanes_s   = sync_q[6];

   // One wait state; a write lands at the edge that sees pready
   assign access = apb_req.psel & apb_req.penable & ~rsp_q.pready;
   assign wr     = apb_req.psel & apb_req.penable & rsp_q.pready & apb_req.pwrite;
   assign rd     = access & ~apb_req.pwrite;
   assign mapped = (apb_req.paddr == `CTRL_OFS)   |
                   (apb_req.paddr == `STATUS_OFS) |
                   (apb_req.paddr == `STICKY_OFS) |
                   (apb_req.paddr == `SCRATCH_OFS);

   // Completion returns before the warm reset takes hold
   assign fundamental_reset_request_pulse = wr & (apb_req.paddr == `CTRL_OFS) &
                       apb_req.pwdata[`CTRL_FUNDAMENTAL_RESET_REQUEST_BIT];
   assign hrst_pulse = wr & (apb_req.paddr == `CTRL_OFS) &
                       apb_req.pwdata[`CTRL_HRST_BIT];
   assign fund_cond  = pin_rst_s | fundamental_reset_request_pulse;
   assign hot_active = (hot_cnt_q != 5'h00);

   // Sequencer; any new fundamental condition drops back to waiting
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         state_q <= switch_reset_sequencer_pkg::st_wait;
      else if (fund_cond)
         state_q <= switch_reset_sequencer_pkg::st_wait;
      else
      begin
         unique case (state_q)
            switch_reset_sequencer_pkg::st_wait:
               state_q <= switch_reset_sequencer_pkg::st_sample;
            switch_reset_sequencer_pkg::st_sample:
               state_q <= switch_reset_sequencer_pkg::st_decode;
            switch_reset_sequencer_pkg::st_decode:
               state_q <= switch_reset_sequencer_pkg::st_pll;
            switch_reset_sequencer_pkg::st_pll:
               // Deadline keeps training inside its limit if lock is late
               if ((pll_s & lanes_s) | (since_q >= TRAIN_LIMIT - 25'h2))
                  state_q <= switch_reset_sequencer_pkg::st_train;
            switch_reset_sequencer_pkg::st_train:
               state_q <= switch_reset_sequencer_pkg::st_halt;
            switch_reset_sequencer_pkg::st_halt:
               state_q <= switch_reset_sequencer_pkg::st_quasi;
            switch_reset_sequencer_pkg::st_quasi:
               if (~halt_ctrl_q & ~mode_test)
                  state_q <= switch_reset_sequencer_pkg::st_run;
            switch_reset_sequencer_pkg::st_run:
               state_q <= switch_reset_sequencer_pkg::st_run;
            default:
               state_q <= switch_reset_sequencer_pkg::st_wait;
         endcase
      end
   end

   // Time since the reset condition cleared, saturating
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         since_q <= '0;
      else if (state_q == switch_reset_sequencer_pkg::st_wait)
         since_q <= '0;
      else if (since_q != 25'h1FFFFFF)
         since_q <= since_q + 25'h1;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         forced_q <= 1'b0;
      else if (state_q == switch_reset_sequencer_pkg::st_wait)
         forced_q <= 1'b0;
      else if ((state_q == switch_reset_sequencer_pkg::st_pll) & ~(pll_s & lanes_s) &
               (since_q >= TRAIN_LIMIT - 25'h2))
         forced_q <= 1'b1;
   end

   // Straps sampled only in the sample step
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         mode_q <= '0;
      else if ((state_q == switch_reset_sequencer_pkg::st_sample) & pin_seen_q)
         mode_q <= straps_s;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         pin_seen_q <= 1'b0;
      else if (pin_rst_s)
         pin_seen_q <= 1'b1;
      else if (state_q == switch_reset_sequencer_pkg::st_decode)
         pin_seen_q <= 1'b0;
   end

   // Cold for each pin reset until the sequence first reaches run after power-up
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         fresh_q <= 1'b1;
         cold_q  <= 1'b0;
         warm_q  <= 1'b0;
      end
      else
      begin
         if (state_q == switch_reset_sequencer_pkg::st_run)
            fresh_q <= 1'b0;
         if (pin_rst_s & fresh_q)
         begin
            cold_q <= 1'b1;
            warm_q <= 1'b0;
         end
         else if (fund_cond)
         begin
            cold_q <= 1'b0;
            warm_q <= 1'b1;
         end
      end
   end

   // Halt: hardware set beats a same-cycle software clear
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         halt_stat_q <= 1'b0;
         halt_ctrl_q <= 1'b0;
      end
      else if (fund_cond)
      begin
         halt_stat_q <= 1'b0;
         halt_ctrl_q <= 1'b0;
      end
      else if ((state_q == switch_reset_sequencer_pkg::st_halt) & halt_s)
      begin
         halt_stat_q <= 1'b1;
         halt_ctrl_q <= 1'b1;
      end
      else if (wr & (apb_req.paddr == `CTRL_OFS))
         halt_ctrl_q <= apb_req.pwdata[`CTRL_HALT_BIT];
   end

   // Control bits: cleared by either reset
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         usbr_q    <= 1'b0;
         dsbr_q    <= '0;
         scratch_q <= '0;
      end
      else if (fund_cond | hot_active)
      begin
         usbr_q    <= 1'b0;
         dsbr_q    <= '0;
         scratch_q <= '0;
      end
      else if (wr & (apb_req.paddr == `CTRL_OFS))
      begin
         usbr_q <= apb_req.pwdata[`CTRL_USBR_BIT];
         dsbr_q <= apb_req.pwdata[`CTRL_DSBR_LSB +: 3];
      end
      else if (wr & (apb_req.paddr == `SCRATCH_OFS))
         scratch_q <= apb_req.pwdata;
   end

   // Sticky field survives hot reset, not fundamental reset
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         sticky_q <= '0;
      else if (fund_cond)
         sticky_q <= '0;
      else if (wr & (apb_req.paddr == `STICKY_OFS))
         sticky_q <= apb_req.pwdata;
   end

   // Hot reset pulse; a fundamental reset supersedes it
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         hot_cnt_q <= '0;
      else if (fund_cond)
         hot_cnt_q <= '0;
      else if ((hot_reset_in | hrst_pulse) &
               (state_q == switch_reset_sequencer_pkg::st_run))
         hot_cnt_q <= 5'(`HOT_PULSE_CYC);
      else if (hot_active)
         hot_cnt_q <= hot_cnt_q - 5'h1;
   end

   always_comb
   begin
      rdata = '0;
      unique case (apb_req.paddr)
         `CTRL_OFS:
         begin
            rdata[`CTRL_HALT_BIT]       = halt_ctrl_q;
            rdata[`CTRL_USBR_BIT]       = usbr_q;
            rdata[`CTRL_DSBR_LSB +: 3]  = dsbr_q;
         end
         `STATUS_OFS:
         begin
            rdata[2:0]                  = mode_q;
            rdata[`STAT_HALT_BIT]       = halt_stat_q;
            rdata[`STAT_COLD_BIT]       = cold_q;
            rdata[`STAT_WARM_BIT]       = warm_q;
            rdata[`STAT_FORCE_BIT]      = forced_q;
            rdata[`STAT_STATE_LSB +: 8] = state_q;
         end
         `STICKY_OFS:  rdata = sticky_q;
         `SCRATCH_OFS: rdata = scratch_q;
         default:      rdata = '0;
      endcase
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         rsp_q <= '0;
      else
      begin
         rsp_q.pready  <= access;
         rsp_q.pslverr <= access & ~mapped;
         if (rd)
            rsp_q.prdata <= rdata;
      end
   end

   assign apb_rsp = rsp_q;

   // Step outputs, all registered
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         core_reset        <= 1'b1;
         pll_reset         <= 1'b1;
         lane_reset        <= 1'b1;
         link_train_enable <= 1'b0;
         stack_reset       <= 1'b1;
         quasi_reset       <= 1'b1;
         config_retry      <= 1'b0;
         mode_normal       <= 1'b0;
         mode_eeprom       <= 1'b0;
         mode_test         <= 1'b0;
      end
      else if (fund_cond)
      begin
         core_reset        <= 1'b1;
         pll_reset         <= 1'b1;
         lane_reset        <= 1'b1;
         link_train_enable <= 1'b0;
         stack_reset       <= 1'b1;
         quasi_reset       <= 1'b1;
         config_retry      <= 1'b0;
      end
      else
      begin
         core_reset <= (state_q == switch_reset_sequencer_pkg::st_wait);
         if (state_q == switch_reset_sequencer_pkg::st_decode)
         begin
            mode_normal <= (mode_q == `MODE_NORMAL);
            mode_eeprom <= (mode_q == `MODE_EEPROM);
            mode_test   <= (mode_q != `MODE_NORMAL) & (mode_q != `MODE_EEPROM);
            pll_reset   <= 1'b0;
            lane_reset  <= 1'b0;
         end
         if (state_q == switch_reset_sequencer_pkg::st_train)
            link_train_enable <= 1'b1;
         if ((state_q == switch_reset_sequencer_pkg::st_quasi) & ~mode_test)
         begin
            stack_reset  <= 1'b0;
            config_retry <= 1'b1;
         end
         if (state_q == switch_reset_sequencer_pkg::st_run)
         begin
            quasi_reset  <= 1'b0;
            config_retry <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         logic_hot_reset       <= 1'b0;
         function_hot_reset[0] <= 1'b0;
      end
      else
      begin
         logic_hot_reset       <= hot_active;
         function_hot_reset[0] <= hot_active;
      end
   end

   // Per downstream port: function reset and link propagation
   genvar i;
   generate
      for (i = 0; i < 3; i++)
      begin : g_port
         always_ff @(posedge clock or posedge rst)
         begin
            if (rst)
            begin
               function_hot_reset[i+1] <= 1'b0;
               link_hot_reset[i]       <= 1'b0;
            end
            else
            begin
               function_hot_reset[i+1] <= hot_active | usbr_q;
               link_hot_reset[i]       <= hot_active | usbr_q | dsbr_q[i];
            end
         end
      end
   endgenerate

endmodule // switch_reset_sequencer

// >>> verif/switch_reset_sequencer_asserts.sv
/*
 Checker bound to the reset sequencer top.
 Assumes the header is on the include path.
*/
`timescale 1ns/10ps
`include "switch_reset_sequencer_regs.svh"

module switch_reset_sequencer_asserts #(
   parameter logic [24:0] TRAIN_LIMIT = 25'h32
) (
   input wire logic                                    clock,
   input wire logic                                    rst,
   input wire switch_reset_sequencer_pkg::apb_req_type apb_req,
   input wire switch_reset_sequencer_pkg::apb_rsp_type apb_rsp,
   input wire logic                                    system_reset_in_n,
   input wire logic                                    core_reset,
   input wire logic                                    logic_hot_reset,
   input wire logic                                    pll_reset,
   input wire logic                                    lane_reset,
   input wire logic                                    link_train_enable,
   input wire logic                                    stack_reset,
   input wire logic                                    quasi_reset,
   input wire logic                                    config_retry,
   input wire logic                                    mode_normal,
   input wire logic                                    mode_eeprom,
   input wire logic                                    mode_test,
   input wire logic [3:0]                              function_hot_reset,
   input wire logic [2:0]                              link_hot_reset
);
   logic [24:0] wait_q;
   logic [4:0]  hot_q;
   wire         fundamental_reset_request_wr = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite
                          && apb_req.paddr == `CTRL_OFS && apb_req.pwdata[`CTRL_FUNDAMENTAL_RESET_REQUEST_BIT];

   // Cycles from lane start to training
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         wait_q <= 25'h0;
      else if (pll_reset || link_train_enable)
         wait_q <= 25'h0;
      else
         wait_q <= wait_q + 25'h1;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         hot_q <= 5'h0;
      else
         hot_q <= logic_hot_reset ? hot_q + 5'h1 : 5'h0;
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   a_pin_fundamental: assert property ($fell(system_reset_in_n) |-> ##[1:5] core_reset)
      else $error("pin did not reset");
   a_soft_request: assert property (fundamental_reset_request_wr |-> ##[1:3] core_reset)
      else $error("request did not reset");
   a_wait_release: assert property (!system_reset_in_n [*6] |-> pll_reset && stack_reset && !link_train_enable)
      else $error("advanced while pin held");
   a_lanes_first: assert property ($rose(link_train_enable) |-> !pll_reset && !lane_reset)
      else $error("training before lanes");
   a_train_deadline: assert property (wait_q <= TRAIN_LIMIT)
      else $error("training deadline missed");
   a_mode_onehot: assert property (!pll_reset && !core_reset |-> $onehot({mode_normal, mode_eeprom, mode_test}))
      else $error("mode not one-hot");
   a_quasi_entry: assert property ($fell(stack_reset) |-> quasi_reset && config_retry && !mode_test)
      else $error("stacks released without retry");
   a_test_stacks: assert property (mode_test && !core_reset |-> stack_reset)
      else $error("stacks released in a test mode");
   a_hot_length: assert property ($fell(logic_hot_reset) && !core_reset |-> hot_q == 5'h10)
      else $error("hot pulse length");
   a_hot_fanout: assert property (logic_hot_reset |-> function_hot_reset == 4'hF && link_hot_reset == 3'h7)
      else $error("hot reset not spread");
   a_apb_answer: assert property (apb_req.psel && $rose(apb_req.penable) |=> apb_rsp.pready)
      else $error("access not answered");

   c_soft_request: cover property (fundamental_reset_request_wr);
   c_hot_pulse: cover property ($fell(logic_hot_reset));
   c_test_mode: cover property (mode_test && !core_reset);
endmodule // switch_reset_sequencer_asserts

bind switch_reset_sequencer switch_reset_sequencer_asserts #(.TRAIN_LIMIT(TRAIN_LIMIT)) checks (
   .clock, .rst, .apb_req, .apb_rsp, .system_reset_in_n, .core_reset, .logic_hot_reset,
   .pll_reset, .lane_reset, .link_train_enable, .stack_reset, .quasi_reset, .config_retry,
   .mode_normal, .mode_eeprom, .mode_test, .function_hot_reset, .link_hot_reset
);

// >>> verif/board_model.sv
/*
 Board side: PLL lock and lane ready, prompt or slow.
 Assumes the bench drives pin and straps.
*/
`timescale 1ns/10ps

module board_model (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       pll_reset,
   input  wire logic       lane_reset,
   input  wire logic       pll_dead,
   input  wire logic [3:0] lock_delay,
   output      logic       pll_locked,
   output      logic       lanes_ready
);
   logic [3:0] lock_q;

   // A dead PLL never locks; the deadline must take over
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         lock_q <= 4'h0;
      else if (pll_reset || pll_dead)
         lock_q <= 4'h0;
      else if (lock_q != 4'hF)
         lock_q <= lock_q + 4'h1;
   end

   assign pll_locked  = lock_q >= lock_delay && !pll_dead;
   assign lanes_ready = pll_locked && !lane_reset;
endmodule // board_model

// >>> verif/switch_reset_sequencer_test.sv
/*
 Self-checking bench of the reset sequencer.
 Assumes package, header and checker compiled first.
*/
`timescale 1ns/10ps
`include "switch_reset_sequencer_regs.svh"

module switch_reset_sequencer_test;
   localparam logic [24:0] TRAIN_LIMIT = 25'h32;
   localparam logic [7:0]  RUN         = switch_reset_sequencer_pkg::st_run;
   localparam logic [7:0]  QUASI       = switch_reset_sequencer_pkg::st_quasi;
   switch_reset_sequencer_pkg::apb_req_type apb_req;
   switch_reset_sequencer_pkg::apb_rsp_type apb_rsp;
   logic       clock, rst, system_reset_in_n, reset_halt, hot_reset_in, pll_locked, lanes_ready;
   logic       core_reset, logic_hot_reset, pll_reset, lane_reset, link_train_enable;
   logic       stack_reset, quasi_reset, config_retry, mode_normal, mode_eeprom, mode_test;
   logic       pll_dead, slv_err;
   logic [2:0] switch_mode_straps, link_hot_reset;
   logic [3:0] function_hot_reset, lock_delay;
   int         failures, samples_checked, cycles;

   switch_reset_sequencer #(.TRAIN_LIMIT(TRAIN_LIMIT)) uut (
      .clock, .rst, .apb_req, .apb_rsp, .system_reset_in_n, .switch_mode_straps, .reset_halt,
      .pll_locked, .lanes_ready, .hot_reset_in, .core_reset, .logic_hot_reset, .pll_reset,
      .lane_reset, .link_train_enable, .stack_reset, .quasi_reset, .config_retry, .mode_normal,
      .mode_eeprom, .mode_test, .function_hot_reset, .link_hot_reset
   );

   board_model board (
      .clock, .rst, .pll_reset, .lane_reset, .pll_dead, .lock_delay, .pll_locked, .lanes_ready
   );

   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   task automatic results;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         results();
      end
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [2:0] mode_exp(input logic [2:0] m);
      return m == `MODE_NORMAL ? 3'b100 : m == `MODE_EEPROM ? 3'b010 : 3'b001;
   endfunction

   function automatic logic [31:0] stat_exp(input logic [2:0] m, input logic h,
                                            input logic c, input logic f, input logic [7:0] st);
      return {16'h0, st, 1'b0, f, !c, c, h, m};
   endfunction

   // Request held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                      output logic [31:0] rd);
      int n;
      @(posedge clock);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
      @(posedge clock);
      apb_req.penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (apb_rsp.pready !== 1'b1 && n < 20);
      check("pready", 32'h1, 32'(apb_rsp.pready));
      rd = apb_rsp.prdata;
      slv_err = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask

   // Kind 0: run, 1: halted quasi, 2: training in test mode
   task automatic settle(input int kind);
      int n;
      n = 0;
      while (n < 300 && (kind == 0 ? quasi_reset !== 1'b0 : kind == 1 ?
                         config_retry !== 1'b1 : link_train_enable !== 1'b1))
      begin
         @(posedge clock);
         n++;
      end
      check("settle", 32'h1, 32'(n < 300));
   endtask

   task automatic pin_reset(input logic [2:0] m, input logic h, input int kind);
      @(posedge clock);
      system_reset_in_n <= 1'b0;
      switch_mode_straps <= m;
      reset_halt <= h;
      lock_delay <= 4'($urandom_range(1, 12));
      repeat (8) @(posedge clock);
      system_reset_in_n <= 1'b1;
      settle(kind);
      switch_mode_straps <= 3'($urandom);
      reset_halt <= 1'b0;
   endtask

   initial
   begin
      logic [31:0] rd, sticky;
      logic [2:0]  m;
      rst = 1'b1;
      apb_req = '0;
      system_reset_in_n = 1'b0;
      switch_mode_straps = 3'h0;
      reset_halt = 1'b0;
      hot_reset_in = 1'b0;
      pll_dead = 1'b0;
      lock_delay = 4'h4;
      void'($urandom(32'hAABFF6B7));
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      pin_reset(3'h1, 1'b1, 1);
      apb(1'b0, `STATUS_OFS, 32'h0, rd);
      check("cold status", stat_exp(3'h1, 1'b1, 1'b1, 1'b0, QUASI), rd);
      check("quasi", 32'h3, 32'({stack_reset, quasi_reset, config_retry}));
      apb(1'b1, `CTRL_OFS, 32'h0, rd);
      settle(0);
      check("run", 32'h0, 32'({stack_reset, quasi_reset, config_retry}));
      check("training", 32'h1, 32'(link_train_enable));
      apb(1'b0, 12'h010, 32'h0, rd);
      check("unmapped err", 32'h1, 32'(slv_err));
      check("unmapped rd", 32'h0, rd);
      for (int i = 0; i < 8; i++)
      begin
         m = 3'(i);
         pin_reset(m, 1'b0, m > 3'h1 ? 2 : 0);
         if (m > 3'h1)
            repeat (4) @(posedge clock);
         check("mode", 32'(mode_exp(m)), 32'({mode_normal, mode_eeprom, mode_test}));
         check("stack hold", 32'(m > 3'h1), 32'(stack_reset));
         apb(1'b0, `STATUS_OFS, 32'h0, rd);
         check("status", stat_exp(m, 1'b0, 1'b0, 1'b0, m > 3'h1 ? QUASI : RUN), rd);
      end
      pin_reset(3'h1, 1'b0, 0);
      switch_mode_straps <= 3'h0;
      apb(1'b1, `CTRL_OFS, 32'h1, rd);
      repeat (2) @(posedge clock);
      settle(0);
      apb(1'b0, `STATUS_OFS, 32'h0, rd);
      check("soft status", stat_exp(3'h1, 1'b0, 1'b0, 1'b0, RUN), rd);
      for (int k = 0; k < 2; k++)
      begin
         sticky = $urandom;
         apb(1'b1, `STICKY_OFS, sticky, rd);
         apb(1'b1, `SCRATCH_OFS, ~sticky, rd);
         if (k == 0)
         begin
            hot_reset_in <= 1'b1;
            @(posedge clock);
            hot_reset_in <= 1'b0;
         end
         else
            apb(1'b1, `CTRL_OFS, 32'h2, rd);
         repeat (20) @(posedge clock);
         apb(1'b0, `STICKY_OFS, 32'h0, rd);
         check("sticky kept", sticky, rd);
         apb(1'b0, `SCRATCH_OFS, 32'h0, rd);
         check("scratch", 32'h0, rd);
      end
      pin_reset(3'($urandom_range(0, 1)), 1'b0, 0);
      apb(1'b0, `STICKY_OFS, 32'h0, rd);
      check("sticky clr", 32'h0, rd);
      m = 3'($urandom_range(1, 7));
      apb(1'b1, `CTRL_OFS, {25'h0, m, 4'h0}, rd);
      repeat (3) @(posedge clock);
      check("links", 32'(m), 32'(link_hot_reset));
      apb(1'b1, `CTRL_OFS, 32'h8, rd);
      repeat (3) @(posedge clock);
      check("functions", 32'hE, 32'(function_hot_reset));
      apb(1'b1, `CTRL_OFS, 32'h0, rd);
      pll_dead <= 1'b1;
      pin_reset(3'h0, 1'b0, 0);
      apb(1'b0, `STATUS_OFS, 32'h0, rd);
      check("forced", stat_exp(3'h0, 1'b0, 1'b0, 1'b1, RUN), rd);
      system_reset_in_n <= 1'b0;
      repeat (8) @(posedge clock);
      system_reset_in_n <= 1'b1;
      repeat (12) @(posedge clock);
      system_reset_in_n <= 1'b0;
      repeat (4) @(posedge clock);
      check("restart", 32'h1, 32'({link_train_enable, pll_reset}));
      pll_dead <= 1'b0;
      pin_reset(3'h0, 1'b0, 0);
      check("rerun", 32'h1, 32'(link_train_enable));
      results();
   end
endmodule // switch_reset_sequencer_test
